/* logic/ifd_decoder.sv */
`timescale 1ns/100ps
module ifd_decoder #(
   parameter logic [3:0] P_OP_MOV     = ifd_pkg::OPC_MOV,
   parameter logic [3:0] P_OP_ADD     = ifd_pkg::OPC_ADD,
   parameter logic [3:0] P_OP_SUB     = ifd_pkg::OPC_SUB,
   parameter logic [3:0] P_OP_CMP     = ifd_pkg::OPC_CMP,
   parameter logic [3:0] P_OP_AND     = ifd_pkg::OPC_AND,
   parameter logic [3:0] P_OP_OR      = ifd_pkg::OPC_OR,
   parameter logic [3:0] P_OP_XOR     = ifd_pkg::OPC_XOR,
   parameter logic [3:0] P_OP_SHL     = ifd_pkg::OPC_SHL,
   parameter logic [3:0] P_OP_SHR     = ifd_pkg::OPC_SHR,
   parameter logic [3:0] P_OP_LDM     = ifd_pkg::OPC_LDM,
   parameter logic [3:0] P_OP_STM     = ifd_pkg::OPC_STM,
   parameter logic [3:0] P_OP_JUMP    = ifd_pkg::OPC_JUMP,
   parameter logic [3:0] P_OP_CALL    = ifd_pkg::OPC_CALL,
   parameter logic [3:0] P_OP_EXIT    = ifd_pkg::OPC_EXIT,
   parameter logic [3:0] P_OP_GATE    = ifd_pkg::OPC_GATE,
   parameter logic [3:0] P_OP_COND_BR = ifd_pkg::OPC_COND_BR,
   parameter logic [2:0] P_MODE_REG   = ifd_pkg::MODE_REG_DEF,
   parameter logic [2:0] P_MODE_IND   = ifd_pkg::MODE_IND_DEF,
   parameter logic [2:0] P_MODE_IDX   = ifd_pkg::MODE_IDX_DEF,
   parameter logic [2:0] P_M7_ABS     = ifd_pkg::M7_ABS_DEF,
   parameter logic [2:0] P_M7_INC     = ifd_pkg::M7_INC_DEF,
   parameter logic [2:0] P_M7_DEC     = ifd_pkg::M7_DEC_DEF
) (
   input  wire logic              I_MCLK,
   input  wire logic              I_RST_N,
   input  wire logic              I_IR_LOAD,
   input  wire logic [15:0]       I_IR_WORD,
   input  wire logic [15:0]       I_PC,
   input  wire logic [3:0]        I_PROCESSOR_FLAGS,
   input  wire logic              I_RF_WE,
   input  wire logic [2:0]        I_RF_WADDR,
   input  wire logic [15:0]       I_RF_WDATA,
   input  wire logic              I_EXT_IRQ,
   input  wire logic [4:0]        I_AVS_ADDRESS,
   input  wire logic              I_AVS_READ,
   input  wire logic              I_AVS_WRITE,
   input  wire logic [31:0]       I_AVS_WRITEDATA,
   input  wire logic [3:0]        I_AVS_BYTEENABLE,
   output logic [31:0]            O_AVS_READDATA,
   output logic                   O_AVS_WAITREQUEST,
   output logic                   O_IRQ,
   output logic                   O_DECODE_VALID,
   output logic [3:0]             O_OPCODE,
   output logic [5:0]             O_FIRST_OPERAND_SPEC,
   output logic [5:0]             O_RESULT_OPERAND_SPEC,
   output ifd_pkg::ifd_kind_t     O_FIRST_OPERAND_ADDR_KIND,
   output logic [2:0]             O_FIRST_OPERAND_REG_SEL,
   output logic [4:0]             O_FIRST_OPERAND_IMM,
   output logic                   O_FIRST_OPERAND_USED,
   output logic [15:0]            O_FIRST_OPERAND_VALUE,
   output ifd_pkg::ifd_kind_t     O_RESULT_OPERAND_ADDR_KIND,
   output logic [2:0]             O_RESULT_OPERAND_REG_SEL,
   output logic [4:0]             O_RESULT_OPERAND_IMM,
   output logic                   O_RESULT_OPERAND_USED,
   output logic [15:0]            O_RESULT_OPERAND_VALUE,
   output logic                   O_RESULT_WRITE,
   output logic                   O_CONDITIONAL_BRANCH_INSTR,
   output logic [3:0]             O_BRANCH_TEST_SELECT,
   output logic [15:0]            O_BRANCH_DISPLACEMENT,
   output logic                   O_BRANCH_TAKEN,
   output logic [15:0]            O_BRANCH_TARGET,
   output logic                   O_UNCONDITIONAL_JUMP_INSTR,
   output logic                   O_SUBROUTINE_CALL_INSTR,
   output logic                   O_SUBROUTINE_EXIT_INSTR,
   output logic                   O_INTERRUPT_GATE_INSTR,
   output logic                   O_ILLEGAL_TRAP
);
   import ifd_pkg::*;

   typedef struct packed {
      logic              sync1;
      logic              sync2;
      logic              sync3;
      logic [15:0]       ir;
      logic              pend;
      logic [15:0]       pc;
      logic [3:0]        flags;
      logic [7:0][15:0]  rf;
      logic [3:0]        opcode;
      logic [5:0]        f_spec;
      logic [5:0]        r_spec;
      ifd_spec_t         f_dec;
      ifd_spec_t         r_dec;
      logic              f_used;
      logic              r_used;
      logic [15:0]       f_val;
      logic [15:0]       r_val;
      logic              r_write;
      logic              is_cbr;
      logic              is_jump;
      logic              is_call;
      logic              is_exit;
      logic              is_gate;
      logic [3:0]        br_sel;
      logic [15:0]       br_disp;
      logic              br_taken;
      logic [15:0]       br_target;
      logic              valid;
      logic              trap;
      logic [1:0]        ctrl;
      logic [1:0]        status;
      logic [1:0]        mask;
      logic              ack;
      logic [31:0]       rdata;
   } ifd_state_t;

   ifd_state_t s_reg;
   ifd_state_t s_next;

   // Operand spec decode, shared by both specifiers
   function automatic ifd_spec_t dec_spec(input logic [5:0] sp);
      ifd_spec_t d;
      d = '0;
      d.kind = K_NONE;
      if (!sp[SPEC_MSB]) begin
         d.kind = K_IMM;
         d.imm  = sp[IMM_MSB:0];
      end else if (sp[MODE_MSB:MODE_LSB] == MODE_SPECIAL) begin
         if (sp[RSEL_MSB:0] == P_M7_ABS) begin
            d.kind = K_ABS;
         end else if (sp[RSEL_MSB:0] == P_M7_INC) begin
            d.kind = K_INC;
            d.rsel = SP_INDEX;
         end else if (sp[RSEL_MSB:0] == P_M7_DEC) begin
            d.kind = K_DEC;
            d.rsel = SP_INDEX;
         end else begin
            d.bad = 1'b1;
         end
      end else begin
         d.rsel = sp[RSEL_MSB:0];
         if (sp[MODE_MSB:MODE_LSB] == P_MODE_REG) begin
            d.kind = K_REG;
         end else if (sp[MODE_MSB:MODE_LSB] == P_MODE_IND) begin
            d.kind = K_IND;
         end else if (sp[MODE_MSB:MODE_LSB] == P_MODE_IDX) begin
            d.kind = K_IDX;
         end else begin
            d.rsel = '0;
            d.bad  = 1'b1;
         end
      end
      return d;
   endfunction

   // Instructions that store into the result location
   function automatic logic writes_result(input logic [3:0] op);
      return (op == P_OP_MOV) || (op == P_OP_ADD) || (op == P_OP_SUB) ||
             (op == P_OP_AND) || (op == P_OP_OR) || (op == P_OP_XOR) ||
             (op == P_OP_SHL) || (op == P_OP_SHR) || (op == P_OP_LDM);
   endfunction

   // Branch test on the flags, top select bit inverts
   function automatic logic test_true(input logic [3:0] sel, input logic [3:0] f);
      logic t;
      t = 1'b0;
      unique case (sel[2:0])
         3'h0: t = 1'b1;
         3'h1: t = f[FLAG_Z];
         3'h2: t = f[FLAG_C];
         3'h3: t = f[FLAG_N];
         3'h4: t = f[FLAG_V];
         3'h5: t = f[FLAG_C] | f[FLAG_Z];
         3'h6: t = f[FLAG_N] ^ f[FLAG_V];
         3'h7: t = (f[FLAG_N] ^ f[FLAG_V]) | f[FLAG_Z];
      endcase
      return t ^ sel[3];
   endfunction

   function automatic logic [31:0] read_word(input ifd_state_t s, input logic [4:0] a);
      logic [31:0] w;
      w = '0;
      unique case (a)
         ADDR_CTRL:    w[1:0] = s.ctrl;
         ADDR_STATUS:  w[1:0] = s.status;
         ADDR_MASK:    w[1:0] = s.mask;
         ADDR_LAST_IR: w = {s.pc, s.ir};
         ADDR_FLAGS:   w[FLAGS_TAKEN:0] = {s.br_taken, s.flags};
         default:      w = '0;
      endcase
      return w;
   endfunction

   always_comb begin
      ifd_spec_t  fd;
      ifd_spec_t  rd;
      logic [3:0] op;
      logic       bad;
      logic [1:0] ev;
      logic [1:0] clr;
      logic       req;
      fd  = '0;
      rd  = '0;
      op  = '0;
      bad = 1'b0;
      ev  = '0;
      clr = '0;
      s_next = s_reg;

      // Pin synchroniser and edge detect
      s_next.sync1 = I_EXT_IRQ;
      s_next.sync2 = s_reg.sync1;
      s_next.sync3 = s_reg.sync2;
      ev[EV_EXT_INT] = s_reg.sync2 & ~s_reg.sync3;

      // Register file writes
      for (int i = 0; i < 8; i++) begin
         if (I_RF_WE && (I_RF_WADDR == 3'(i))) begin
            s_next.rf[i] = I_RF_WDATA;
         end
      end

      // Instruction register load
      s_next.pend = I_IR_LOAD;
      if (I_IR_LOAD) begin
         s_next.ir    = I_IR_WORD;
         s_next.pc    = I_PC;
         s_next.flags = I_PROCESSOR_FLAGS;
      end

      // Decode one edge after load
      s_next.valid = 1'b0;
      s_next.trap  = 1'b0;
      if (s_reg.pend) begin
         op = s_reg.ir[OP_MSB:OP_LSB];
         s_next.opcode  = op;
         s_next.f_spec  = s_reg.ir[FIRST_MSB:FIRST_LSB];
         s_next.r_spec  = s_reg.ir[RES_MSB:RES_LSB];
         s_next.is_cbr  = (op == P_OP_COND_BR);
         s_next.is_jump = (op == P_OP_JUMP);
         s_next.is_call = (op == P_OP_CALL);
         s_next.is_exit = (op == P_OP_EXIT);
         s_next.is_gate = (op == P_OP_GATE);
         s_next.f_used  = !(s_next.is_cbr || s_next.is_jump || s_next.is_call ||
                            s_next.is_exit || s_next.is_gate);
         s_next.r_used  = !(s_next.is_cbr || s_next.is_exit || s_next.is_gate);
         s_next.r_write = writes_result(op);
         fd = dec_spec(s_reg.ir[FIRST_MSB:FIRST_LSB]);
         rd = dec_spec(s_reg.ir[RES_MSB:RES_LSB]);
         if (!s_next.f_used) begin
            fd = '0;
            fd.kind = K_NONE;
         end
         if (!s_next.r_used) begin
            rd = '0;
            rd.kind = K_NONE;
         end
         s_next.f_dec = fd;
         s_next.r_dec = rd;
         s_next.f_val = s_reg.rf[fd.rsel];
         s_next.r_val = s_reg.rf[rd.rsel];
         s_next.br_sel   = s_reg.ir[TEST_MSB:TEST_LSB];
         s_next.br_disp  = {{8{s_reg.ir[DISP_MSB]}}, s_reg.ir[DISP_MSB:0]};
         s_next.br_taken = s_next.is_cbr && test_true(s_next.br_sel, s_reg.flags);
         s_next.br_target = s_next.br_taken ? 16'(s_reg.pc + s_next.br_disp) :
                                              s_reg.pc;
         bad = fd.bad | rd.bad |
               (s_reg.ctrl[CTRL_IMM_DEST] & s_next.r_write & (rd.kind == K_IMM));
         s_next.valid = 1'b1;
         s_next.trap  = bad & s_reg.ctrl[CTRL_TRAP_EN];
         ev[EV_ILLEGAL] = s_next.trap;
      end

      // Avalon slave, one wait cycle per access
      req = I_AVS_READ | I_AVS_WRITE;
      s_next.ack = req & ~s_reg.ack;
      if (I_AVS_READ && !s_reg.ack) begin
         s_next.rdata = read_word(s_reg, I_AVS_ADDRESS);
      end
      if (I_AVS_WRITE && s_reg.ack && I_AVS_BYTEENABLE[0]) begin
         unique case (I_AVS_ADDRESS)
            ADDR_CTRL:   s_next.ctrl = I_AVS_WRITEDATA[1:0];
            ADDR_STATUS: clr = I_AVS_WRITEDATA[1:0];
            ADDR_MASK:   s_next.mask = I_AVS_WRITEDATA[1:0];
            default:     clr = '0;
         endcase
      end

      // Sticky events, set wins over clear
      s_next.status = (s_reg.status & ~clr) | ev;
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         s_reg      <= '0;
         s_reg.ctrl <= CTRL_RST;
         s_reg.mask <= MASK_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign O_AVS_READDATA             = s_reg.rdata;
   assign O_AVS_WAITREQUEST          = (I_AVS_READ | I_AVS_WRITE) & ~s_reg.ack;
   assign O_IRQ                      = |(s_reg.status & s_reg.mask);
   assign O_DECODE_VALID             = s_reg.valid;
   assign O_OPCODE                   = s_reg.opcode;
   assign O_FIRST_OPERAND_SPEC       = s_reg.f_spec;
   assign O_RESULT_OPERAND_SPEC      = s_reg.r_spec;
   assign O_FIRST_OPERAND_ADDR_KIND  = s_reg.f_dec.kind;
   assign O_FIRST_OPERAND_REG_SEL    = s_reg.f_dec.rsel;
   assign O_FIRST_OPERAND_IMM        = s_reg.f_dec.imm;
   assign O_FIRST_OPERAND_USED       = s_reg.f_used;
   assign O_FIRST_OPERAND_VALUE      = s_reg.f_val;
   assign O_RESULT_OPERAND_ADDR_KIND = s_reg.r_dec.kind;
   assign O_RESULT_OPERAND_REG_SEL   = s_reg.r_dec.rsel;
   assign O_RESULT_OPERAND_IMM       = s_reg.r_dec.imm;
   assign O_RESULT_OPERAND_USED      = s_reg.r_used;
   assign O_RESULT_OPERAND_VALUE     = s_reg.r_val;
   assign O_RESULT_WRITE             = s_reg.r_write;
   assign O_CONDITIONAL_BRANCH_INSTR = s_reg.is_cbr;
   assign O_BRANCH_TEST_SELECT       = s_reg.br_sel;
   assign O_BRANCH_DISPLACEMENT      = s_reg.br_disp;
   assign O_BRANCH_TAKEN             = s_reg.br_taken;
   assign O_BRANCH_TARGET            = s_reg.br_target;
   assign O_UNCONDITIONAL_JUMP_INSTR = s_reg.is_jump;
   assign O_SUBROUTINE_CALL_INSTR    = s_reg.is_call;
   assign O_SUBROUTINE_EXIT_INSTR    = s_reg.is_exit;
   assign O_INTERRUPT_GATE_INSTR     = s_reg.is_gate;
   assign O_ILLEGAL_TRAP             = s_reg.trap;

   // Checks
   logic [3:0] ir_op_w;
   logic [5:0] ir_first_w;
   logic [5:0] ir_res_w;
   logic       pend_w;
   assign ir_op_w    = s_reg.ir[OP_MSB:OP_LSB];
   assign ir_first_w = s_reg.ir[FIRST_MSB:FIRST_LSB];
   assign ir_res_w   = s_reg.ir[RES_MSB:RES_LSB];
   assign pend_w     = s_reg.pend;

   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);

   property p_opcode;
      pend_w |=> (O_OPCODE == $past(ir_op_w));
   endproperty
   a_opcode: assert property (p_opcode) else $error("opcode field wrong");

   property p_specs;
      pend_w |=> (O_FIRST_OPERAND_SPEC == $past(ir_first_w)) &&
                 (O_RESULT_OPERAND_SPEC == $past(ir_res_w));
   endproperty
   a_specs: assert property (p_specs) else $error("operand spec fields wrong");

   property p_load_to_valid;
      I_IR_LOAD |-> ##2 O_DECODE_VALID;
   endproperty
   a_load_to_valid: assert property (p_load_to_valid) else $error("decode not two edges after load");

   property p_jump;
      O_DECODE_VALID && (O_UNCONDITIONAL_JUMP_INSTR || O_SUBROUTINE_CALL_INSTR) |->
         !O_FIRST_OPERAND_USED && (O_FIRST_OPERAND_ADDR_KIND == K_NONE) && O_RESULT_OPERAND_USED;
   endproperty
   a_jump: assert property (p_jump) else $error("jump used first spec");

   property p_no_operand;
      O_DECODE_VALID && (O_SUBROUTINE_EXIT_INSTR || O_INTERRUPT_GATE_INSTR) |->
         !O_FIRST_OPERAND_USED && !O_RESULT_OPERAND_USED && !O_ILLEGAL_TRAP;
   endproperty
   a_no_operand: assert property (p_no_operand) else $error("operandless op evaluated modes");

   property p_imm;
      O_DECODE_VALID && O_RESULT_OPERAND_USED && !O_RESULT_OPERAND_SPEC[SPEC_MSB] |->
         (O_RESULT_OPERAND_ADDR_KIND == K_IMM) &&
         (O_RESULT_OPERAND_IMM == O_RESULT_OPERAND_SPEC[IMM_MSB:0]);
   endproperty
   a_imm: assert property (p_imm) else $error("short immediate decode wrong");

   property p_stack;
      O_DECODE_VALID && ((O_FIRST_OPERAND_ADDR_KIND == K_INC) ||
                         (O_FIRST_OPERAND_ADDR_KIND == K_DEC)) |->
         (O_FIRST_OPERAND_REG_SEL == SP_INDEX) && (O_FIRST_OPERAND_SPEC[5:3] == MODE_SPECIAL);
   endproperty
   a_stack: assert property (p_stack) else $error("stack mode not on register seven");

   property p_branch;
      O_DECODE_VALID && O_CONDITIONAL_BRANCH_INSTR |->
         (O_BRANCH_TEST_SELECT == O_FIRST_OPERAND_SPEC[5:2]) &&
         (O_BRANCH_DISPLACEMENT[7:0] == {O_FIRST_OPERAND_SPEC[1:0], O_RESULT_OPERAND_SPEC}) &&
         (O_BRANCH_DISPLACEMENT[15:8] == {8{O_FIRST_OPERAND_SPEC[1]}});
   endproperty
   a_branch: assert property (p_branch) else $error("branch fields wrong");

   property p_trap_sticky;
      O_ILLEGAL_TRAP |=> s_reg.status[EV_ILLEGAL];
   endproperty
   a_trap_sticky: assert property (p_trap_sticky) else $error("trap not recorded");

   property p_wait;
      (I_AVS_READ && !O_AVS_WAITREQUEST) |-> $past(O_AVS_WAITREQUEST);
   endproperty
   a_wait: assert property (p_wait) else $error("read answered without wait cycle");

   c_taken:   cover property (O_DECODE_VALID && O_BRANCH_TAKEN);
   c_illegal: cover property (O_ILLEGAL_TRAP ##1 O_IRQ);
   c_dec:     cover property (O_DECODE_VALID && (O_RESULT_OPERAND_ADDR_KIND == K_DEC));

endmodule

/* logic/ifd_pkg.sv */
package ifd_pkg;

   // Word and field geometry
   localparam int WORD_W    = 16;
   localparam int OP_MSB    = 15;
   localparam int OP_LSB    = 12;
   localparam int FIRST_MSB = 11;
   localparam int FIRST_LSB = 6;
   localparam int RES_MSB   = 5;
   localparam int RES_LSB   = 0;
   localparam int TEST_MSB  = 11;
   localparam int TEST_LSB  = 8;
   localparam int DISP_MSB  = 7;
   localparam int SPEC_MSB  = 5;
   localparam int MODE_MSB  = 5;
   localparam int MODE_LSB  = 3;
   localparam int IMM_MSB   = 4;
   localparam int RSEL_MSB  = 2;

   // Default opcode values
   localparam logic [3:0] OPC_MOV     = 4'h0;
   localparam logic [3:0] OPC_ADD     = 4'h1;
   localparam logic [3:0] OPC_SUB     = 4'h2;
   localparam logic [3:0] OPC_CMP     = 4'h3;
   localparam logic [3:0] OPC_AND     = 4'h4;
   localparam logic [3:0] OPC_OR      = 4'h5;
   localparam logic [3:0] OPC_XOR     = 4'h6;
   localparam logic [3:0] OPC_SHL     = 4'h7;
   localparam logic [3:0] OPC_SHR     = 4'h8;
   localparam logic [3:0] OPC_LDM     = 4'h9;
   localparam logic [3:0] OPC_STM     = 4'hA;
   localparam logic [3:0] OPC_JUMP    = 4'hB;
   localparam logic [3:0] OPC_CALL    = 4'hC;
   localparam logic [3:0] OPC_EXIT    = 4'hD;
   localparam logic [3:0] OPC_GATE    = 4'hE;
   localparam logic [3:0] OPC_COND_BR = 4'hF;

   // Default mode codes
   localparam logic [2:0] MODE_REG_DEF = 3'h4;
   localparam logic [2:0] MODE_IND_DEF = 3'h5;
   localparam logic [2:0] MODE_IDX_DEF = 3'h6;
   localparam logic [2:0] MODE_SPECIAL = 3'h7;
   localparam logic [2:0] M7_ABS_DEF   = 3'h0;
   localparam logic [2:0] M7_INC_DEF   = 3'h1;
   localparam logic [2:0] M7_DEC_DEF   = 3'h2;
   localparam logic [2:0] SP_INDEX     = 3'h7;

   // Flag positions
   localparam int FLAG_N = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_V = 1;
   localparam int FLAG_C = 0;

   // Register map, byte addresses
   localparam logic [4:0] ADDR_CTRL    = 5'h00;
   localparam logic [4:0] ADDR_STATUS  = 5'h04;
   localparam logic [4:0] ADDR_MASK    = 5'h08;
   localparam logic [4:0] ADDR_LAST_IR = 5'h0C;
   localparam logic [4:0] ADDR_FLAGS   = 5'h10;

   localparam int CTRL_TRAP_EN   = 0;
   localparam int CTRL_IMM_DEST  = 1;
   localparam int EV_ILLEGAL     = 0;
   localparam int EV_EXT_INT     = 1;
   localparam int FLAGS_TAKEN    = 4;

   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam logic [1:0] MASK_RST = 2'h0;

   typedef enum logic [2:0] {
      K_NONE, K_IMM, K_REG, K_IND, K_IDX, K_ABS, K_INC, K_DEC
   } ifd_kind_t;

   typedef struct packed {
      ifd_kind_t  kind;
      logic [2:0] rsel;
      logic [4:0] imm;
      logic       bad;
   } ifd_spec_t;

endpackage

/* verif/ifd_seq_model.sv */
`timescale 1ns/100ps
module ifd_seq_model (
   input  wire logic        i_clk,
   output logic             o_load    = 1'b0,
   output logic [15:0]      o_word    = 16'h0000,
   output logic [15:0]      o_pc      = 16'h0000,
   output logic [3:0]       o_flags   = 4'h0,
   output logic             o_rf_we   = 1'b0,
   output logic [2:0]       o_rf_addr = 3'h0,
   output logic [15:0]      o_rf_data = 16'h0000
);
   // One load strobe per instruction, word inverted once released
   task issue(input logic [15:0] w, input logic [15:0] p, input logic [3:0] f);
      @(posedge i_clk);
      o_load <= 1'b1;
      o_word <= w;
      o_pc <= p;
      o_flags <= f;
      @(posedge i_clk);
      o_load <= 1'b0;
      o_word <= ~w;
   endtask
   task rf(input logic [2:0] a, input logic [15:0] d);
      @(posedge i_clk);
      o_rf_we <= 1'b1;
      o_rf_addr <= a;
      o_rf_data <= d;
      @(posedge i_clk);
      o_rf_we <= 1'b0;
      o_rf_data <= ~d;
   endtask
endmodule

/* verif/cpu_instruction_field_decoder_test.sv */
`timescale 1ns/100ps
module cpu_instruction_field_decoder_test;
   import ifd_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ext = 1'b0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [4:0]  addr = 5'h00;
   logic [31:0] wdata = 32'h0, rdata, bus_q;
   logic        wt_rq, irq, vld, trap, t_seen, ld, rf_we, fu, ru, rw, conditional_branch_instr, unconditional_jump_instr, ex, gt, tk, cl;
   logic [15:0] word, pc, rf_d, disp, tgt, rval, fval;
   logic [3:0]  flags, opc, tsel;
   logic [2:0]  rf_a, fsel, rsel;
   logic [4:0]  fimm;
   ifd_kind_t   fk, rk;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   always #4 clk = ~clk;
   ifd_seq_model seq (.i_clk(clk), .o_load(ld), .o_word(word), .o_pc(pc), .o_flags(flags),
      .o_rf_we(rf_we), .o_rf_addr(rf_a), .o_rf_data(rf_d));
   ifd_decoder uut (.I_MCLK(clk), .I_RST_N(rst_n), .I_IR_LOAD(ld), .I_IR_WORD(word),
      .I_PC(pc), .I_PROCESSOR_FLAGS(flags), .I_RF_WE(rf_we), .I_RF_WADDR(rf_a),
      .I_RF_WDATA(rf_d), .I_EXT_IRQ(ext), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
      .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hF),
      .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wt_rq), .O_IRQ(irq), .O_DECODE_VALID(vld),
      .O_OPCODE(opc), .O_FIRST_OPERAND_SPEC(), .O_RESULT_OPERAND_SPEC(),
      .O_FIRST_OPERAND_ADDR_KIND(fk), .O_FIRST_OPERAND_REG_SEL(fsel),
      .O_FIRST_OPERAND_IMM(fimm), .O_FIRST_OPERAND_USED(fu), .O_FIRST_OPERAND_VALUE(fval),
      .O_RESULT_OPERAND_ADDR_KIND(rk), .O_RESULT_OPERAND_REG_SEL(rsel),
      .O_RESULT_OPERAND_IMM(), .O_RESULT_OPERAND_USED(ru), .O_RESULT_OPERAND_VALUE(rval),
      .O_RESULT_WRITE(rw), .O_CONDITIONAL_BRANCH_INSTR(conditional_branch_instr), .O_BRANCH_TEST_SELECT(tsel),
      .O_BRANCH_DISPLACEMENT(disp), .O_BRANCH_TAKEN(tk), .O_BRANCH_TARGET(tgt),
      .O_UNCONDITIONAL_JUMP_INSTR(unconditional_jump_instr), .O_SUBROUTINE_CALL_INSTR(cl),
      .O_SUBROUTINE_EXIT_INSTR(ex), .O_INTERRUPT_GATE_INSTR(gt), .O_ILLEGAL_TRAP(trap));
   task results;
      if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         results();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do @(posedge clk); while (wt_rq !== 1'b0);
      bus_q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task dec(input logic [15:0] w, input logic [15:0] p, input logic [3:0] f);
      seq.issue(w, p, f);
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         if (vld === 1'b1) break;
      end
      t_seen = trap;
      chk(vld, 1'b1);
   endtask
   task s_regs;
      seq.rf(3'h2, 16'hBEEF);
      dec(16'h1862, 16'h0000, 4'h0);
      chk(opc, 4'h1);
      chk({fk, fsel, rk, rsel}, {K_REG, 3'h1, K_REG, 3'h2});
      chk({rval, rw}, {16'hBEEF, 1'b1});
      dec(16'h0163, 16'h0000, 4'h0);
      chk({fk, fimm, rk, rsel}, {K_IMM, 5'h05, K_REG, 3'h3});
      dec(16'h3EB8, 16'h0000, 4'h0);
      chk({opc, fk, fsel, rk, rsel}, {4'h3, K_DEC, 3'h7, K_ABS, 3'h0});
      seq.rf(3'h4, 16'h1234);
      dec(16'h0B39, 16'h0000, 4'h0);
      chk({fk, fsel, rk, rsel, fval}, {K_IND, 3'h4, K_INC, 3'h7, 16'h1234});
   endtask
   task s_branch;
      dec(16'hF180, 16'h0100, 4'h4);
      chk({conditional_branch_instr, tsel, disp}, {1'b1, 4'h1, 16'hFF80});
      chk({tk, tgt}, {1'b1, 16'h0080});
      dec(16'hF980, 16'h0100, 4'h4);
      chk({tk, tgt}, {1'b0, 16'h0100});
   endtask
   task s_noops;
      dec(16'hBFE5, 16'h0000, 4'h0);
      chk({unconditional_jump_instr, fu, t_seen, rk, rsel}, {1'b1, 1'b0, 1'b0, K_REG, 3'h5});
      dec(16'hCFF3, 16'h0000, 4'h0);
      chk({cl, fu, t_seen, rk, rsel}, {1'b1, 1'b0, 1'b0, K_IDX, 3'h3});
      dec(16'hDFFF, 16'h0000, 4'h0);
      chk({ex, fu, ru, t_seen}, 4'b1000);
      dec(16'hEFFF, 16'h0000, 4'h0);
      chk({gt, fu, ru, t_seen}, 4'b1000);
   endtask
   task s_irq;
      bus(1'b0, 5'h00, 32'h0);
      chk(bus_q, 32'h1);
      bus(1'b0, 5'h14, 32'h0);
      chk(bus_q, 32'h0);
      bus(1'b1, 5'h08, 32'h3);
      dec(16'h003B, 16'h0000, 4'h0);
      chk(t_seen, 1'b1);
      bus(1'b0, 5'h04, 32'h0);
      chk({bus_q, irq}, {32'h1, 1'b1});
      bus(1'b1, 5'h04, 32'h1);
      @(negedge clk);
      chk(irq, 1'b0);
      @(posedge clk);
      ext <= 1'b1;
      for (int i = 0; i < 10 && irq !== 1'b1; i++) @(negedge clk);
      chk(irq, 1'b1);
      bus(1'b0, 5'h04, 32'h0);
      chk(bus_q, 32'h2);
   endtask
   task s_ctrl;
      bus(1'b1, 5'h00, 32'h3);
      dec(16'h0105, 16'h0000, 4'h0);
      chk(t_seen, 1'b1);
      bus(1'b0, 5'h04, 32'h0);
      chk(bus_q, 32'h3);
      bus(1'b1, 5'h04, 32'h3);
      bus(1'b1, 5'h00, 32'h0);
      dec(16'h003B, 16'h0000, 4'h0);
      chk(t_seen, 1'b0);
      bus(1'b0, 5'h04, 32'h0);
      chk(bus_q, 32'h0);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk({vld, fk, rk, irq}, {1'b0, K_NONE, K_NONE, 1'b0});
      s_regs();
      s_branch();
      s_noops();
      s_irq();
      s_ctrl();
      results();
   end
endmodule
